// [hw/qmc_pkg.sv]
`default_nettype none
package qmc_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] OFS_REVISION  = 8'h00;
    localparam logic [7:0] OFS_MOVE_CMD  = 8'h08;
    localparam logic [7:0] OFS_L0_BASE   = 8'h0c;
    localparam logic [7:0] OFS_L0_SIZE   = 8'h10;
    localparam logic [7:0] OFS_L1_BASE   = 8'h14;
    localparam logic [7:0] OFS_STARVE_LO = 8'h20;
    localparam logic [7:0] OFS_STARVE_HI = 8'h5c;
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;
    // move command fields
    localparam int         MV_HEAD_BIT   = 31;
    localparam int         MV_DST_LSB    = 16;
    localparam int         MV_SRC_LSB    = 0;
    localparam int         QNUM_W        = 14;
    // revision word fields
    localparam int         RV_SCHEME_LSB = 30;
    localparam int         RV_FUNC_LSB   = 16;
    localparam int         RV_RTL_LSB    = 11;
    localparam int         RV_MAJ_LSB    = 8;
    localparam int         RV_CUST_LSB   = 6;
    localparam int         RV_MIN_LSB    = 0;
    localparam logic [1:0]  RV_SCHEME    = 2'h1;
    localparam logic [11:0] RV_FUNC      = 12'h5a1; // arbitrary identifier
    localparam logic [4:0]  RV_RTL       = 5'h01;
    localparam logic [2:0]  RV_MAJ       = 3'h0;
    localparam logic [1:0]  RV_CUST      = 2'h0;
    localparam logic [5:0]  RV_MIN       = 6'h00;
    // linking ram mapping
    localparam int         LINK_IDX_W    = 19;
    localparam int         LINK_SHIFT    = 2;  // one 32-bit word per entry
    // starvation counters
    localparam int         STARVE_GROUPS = 16;
    localparam int         STARVE_NUM    = 64;
    localparam int         STARVE_W      = 8;
    localparam logic [7:0] STARVE_MAX    = 8'hff;
    localparam int         GRP_SEL_LSB   = 2;
    localparam int         GRP_SEL_W     = 4;
endpackage
`default_nettype wire

// [hw/qmc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface qmc_link_if;
    import qmc_pkg::*;
    logic [LINK_IDX_W-1:0] idx;
    logic                  idx_valid;
    logic [31:0]           base0;
    logic [LINK_IDX_W-1:0] count0;
    logic [31:0]           base1;
    logic [31:0]           addr;
    logic                  addr_valid;
    modport calc (input idx, idx_valid, base0, count0, base1,
                  output addr, addr_valid);
    modport cfg  (output idx, idx_valid, base0, count0, base1,
                  input addr, addr_valid);
endinterface
`default_nettype wire

// [hw/qmc_starve_cnt.sv]
`timescale 1ns/1ps
`default_nettype none
module qmc_starve_cnt
    import qmc_pkg::*;
(
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    // events
    input  wire logic                bump,
    input  wire logic                clr,
    // count
    output logic [STARVE_W-1:0]      count_q
);
    logic [STARVE_W-1:0] count_d;
    wire                 at_max = (count_q == STARVE_MAX);

    // clear on read, but an event in that cycle still counts; saturate
    assign count_d = clr ? {{(STARVE_W-1){1'b0}}, bump}
                   : (bump && !at_max) ? count_q + 8'h01
                   : count_q;

    // counter storage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 8'h00;
        end else if (clk_en) begin
            count_q <= count_d;
        end
    end

    a_starve_sat_hold: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        clk_en && at_max && !clr |=> count_q == STARVE_MAX)
        else $error("starvation counter left saturation");
    a_starve_read_clr: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        clk_en && clr && !bump |=> count_q == 8'h00)
        else $error("starvation counter not cleared by read");
endmodule
`default_nettype wire

// [hw/qmc_link_calc.sv]
`timescale 1ns/1ps
`default_nettype none
module qmc_link_calc
    import qmc_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   rst_n,
    input  wire logic   clk_en,
    // mapping request and answer
    qmc_link_if.calc    lk
);
    wire                  in_r0   = (lk.idx <= lk.count0);
    wire [LINK_IDX_W-1:0] r1_off  = lk.idx - lk.count0 - 19'h00001;
    wire [31:0]           r0_addr = lk.base0 + (32'(lk.idx) << LINK_SHIFT);
    wire [31:0]           r1_addr = lk.base1 + (32'(r1_off) << LINK_SHIFT);

    // registered address; base assumed word aligned by software
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk.addr       <= 32'h0000_0000;
            lk.addr_valid <= 1'b0;
        end else if (clk_en) begin
            lk.addr_valid <= lk.idx_valid;
            if (lk.idx_valid) begin
                lk.addr <= in_r0 ? r0_addr : r1_addr;
            end
        end
    end

    a_link_region0: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        clk_en && lk.idx_valid && in_r0 |=> lk.addr == $past(r0_addr))
        else $error("region 0 index mapped to wrong address");
    a_link_region1: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        clk_en && lk.idx_valid && !in_r0 |=> lk.addr == $past(r1_addr))
        else $error("region 1 index mapped to wrong address");
endmodule
`default_nettype wire

// [hw/qmc_config_region.sv]
// How it works
// - registers are read and written only as whole 32-bit words
// - writing the move command moves a whole source queue onto destination
// - moves are serialised; a pending move waits for the current one
// - command bit 31 clear appends at tail, set places at head
// - command bits 29-16 hold local destination queue, 0 to 16383
// - command bits 13-0 hold local source queue, 0 to 16383
// - unused command and revision bits read zero and ignore writes
// - linking address of region 0 indexes comes from region 0 base
// - region 0 size register sets the highest index that lives in region 0
// - indexes above region 0 size use region 1 base
// - sixteen words at 0x20 to 0x5c report starvation counts
// - revision word shows rtl, major and minor revision fields
// - revision word shows scheme, function and custom revision fields
// - 8-bit counters count empty pops, clear on read, saturate at 0xff
// - index not above 19-bit region 0 size lies in region 0
`timescale 1ns/1ps
`default_nettype none
module qmc_config_region
    import qmc_pkg::*;
(
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    // word-wide register port
    input  wire logic [ADDR_W-1:0]      reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [DATA_W-1:0]      reg_wdata,
    output logic [DATA_W-1:0]           reg_rdata_q,
    output logic                        reg_wr_ready_q,
    // queue move request to the queue engine
    output logic                        move_req_q,
    output logic                        move_head_q,
    output logic [QNUM_W-1:0]           move_dst_q,
    output logic [QNUM_W-1:0]           move_src_q,
    input  wire logic                   move_done,
    // descriptor index to linking address
    input  wire logic [LINK_IDX_W-1:0]  link_idx,
    input  wire logic                   link_idx_valid,
    output logic [31:0]                 link_addr,
    output logic                        link_addr_valid,
    // pops of empty free queues
    input  wire logic [STARVE_NUM-1:0]  starve_pop
);
    // configuration registers
    logic [31:0]           l0_base_q;
    logic [LINK_IDX_W-1:0] l0_count_q;
    logic [31:0]           l1_base_q;

    // pending move slot
    logic                  pend_q;
    logic                  pend_head_q;
    logic [QNUM_W-1:0]     pend_dst_q;
    logic [QNUM_W-1:0]     pend_src_q;

    // address decode; only whole words exist, no byte lanes
    wire hit_rev    = (reg_addr == OFS_REVISION);
    wire hit_move   = (reg_addr == OFS_MOVE_CMD);
    wire hit_l0b    = (reg_addr == OFS_L0_BASE);
    wire hit_l0s    = (reg_addr == OFS_L0_SIZE);
    wire hit_l1b    = (reg_addr == OFS_L1_BASE);
    wire hit_starve = (reg_addr >= OFS_STARVE_LO) &&
                      (reg_addr <= OFS_STARVE_HI) &&
                      (reg_addr[1:0] == 2'h0);
    wire [ADDR_W-1:0]    starve_ofs = reg_addr - OFS_STARVE_LO;
    wire [GRP_SEL_W-1:0] grp_sel    =
        starve_ofs[GRP_SEL_LSB +: GRP_SEL_W];

    // write and read strobes
    wire wr_en   = clk_en && reg_wr;
    wire wr_move = wr_en && hit_move && reg_wr_ready_q;
    wire rd_en   = clk_en && reg_rd;

    // command fields; bits 30 and 15-14 are dropped
    wire              cmd_head = reg_wdata[MV_HEAD_BIT];
    wire [QNUM_W-1:0] cmd_dst  = reg_wdata[MV_DST_LSB +: QNUM_W];
    wire [QNUM_W-1:0] cmd_src  = reg_wdata[MV_SRC_LSB +: QNUM_W];

    // revision word; bits 29-28 stay zero
    wire [31:0] rev_word = {RV_SCHEME, 2'h0, RV_FUNC,
                            RV_RTL, RV_MAJ,
                            RV_CUST,
                            RV_MIN};

    // move sequencing conditions
    wire move_end   = move_req_q && move_done;
    wire start_new  = wr_move && (!move_req_q || (move_end && !pend_q));
    wire take_pend  = move_end && pend_q;
    wire park_new   = wr_move && !start_new;

    // starvation counters, one per free queue
    logic [STARVE_W-1:0] starve_cnt [STARVE_NUM];
    wire                 rd_starve = rd_en && hit_starve;

    genvar gi;
    generate
        for (gi = 0; gi < STARVE_NUM; gi++) begin : g_starve
            wire clr_i = rd_starve &&
                (grp_sel == GRP_SEL_W'(gi / 4));
            qmc_starve_cnt u_cnt (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .clk_en  (clk_en),
                .bump    (starve_pop[gi]),
                .clr     (clr_i),
                .count_q (starve_cnt[gi])
            );
        end
    endgenerate

    // four counters of the selected group, lowest queue in low byte
    wire [31:0] starve_word = {starve_cnt[{grp_sel, 2'h3}],
                               starve_cnt[{grp_sel, 2'h2}],
                               starve_cnt[{grp_sel, 2'h1}],
                               starve_cnt[{grp_sel, 2'h0}]};

    // a read clears all four counters of its word
    a_starve_clr_all: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        rd_starve && grp_sel == 4'h1 && starve_pop[7:4] == 4'h0
        |=> starve_cnt[4] == 8'h00 && starve_cnt[7] == 8'h00)
        else $error("starvation word read left a counter set");

    // read data selection; move word and unmapped read as zero
    wire [31:0] rd_word =
        hit_rev    ? rev_word :
        hit_l0b    ? l0_base_q :
        hit_l0s    ? {13'h0000, l0_count_q} :
        hit_l1b    ? l1_base_q :
        hit_starve ? starve_word :
        32'h0000_0000;

    // read data register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            reg_rdata_q <= rd_word;
        end
    end

    // words outside the map read as zero
    a_read_unmapped: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        rd_en && !(hit_rev || hit_l0b || hit_l0s || hit_l1b || hit_starve)
        |=> reg_rdata_q == 32'h0000_0000)
        else $error("unmapped word did not read zero");

    // read data holds between reads
    a_read_hold: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        !rd_en |=> $stable(reg_rdata_q))
        else $error("read data changed without a read");

    // linking configuration registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            l0_base_q  <= 32'h0000_0000;
            l0_count_q <= 19'h00000;
            l1_base_q  <= 32'h0000_0000;
        end else if (wr_en) begin
            if (hit_l0b) l0_base_q  <= reg_wdata;
            if (hit_l0s) l0_count_q <= reg_wdata[LINK_IDX_W-1:0];
            if (hit_l1b) l1_base_q  <= reg_wdata;
        end
    end

    // base registers take the whole written word
    a_base0_store: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        wr_en && hit_l0b |=> l0_base_q == $past(reg_wdata))
        else $error("region 0 base did not take write");

    a_base1_store: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        wr_en && hit_l1b |=> l1_base_q == $past(reg_wdata))
        else $error("region 1 base did not take write");

    // a frozen clock keeps every setting
    a_cfg_frozen: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        !clk_en |=> $stable(l0_base_q) && $stable(l0_count_q)
            && $stable(l1_base_q))
        else $error("settings changed while clock enable low");

    // active move: start, hand over from pending slot, or end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            move_req_q  <= 1'b0;
            move_head_q <= 1'b0;
            move_dst_q  <= 14'h0000;
            move_src_q  <= 14'h0000;
        end else if (clk_en) begin
            if (start_new) begin
                move_req_q  <= 1'b1;
                move_head_q <= cmd_head;
                move_dst_q  <= cmd_dst;
                move_src_q  <= cmd_src;
            end else if (take_pend) begin
                move_req_q  <= 1'b1;
                move_head_q <= pend_head_q;
                move_dst_q  <= pend_dst_q;
                move_src_q  <= pend_src_q;
            end else if (move_end) begin
                move_req_q  <= 1'b0;
            end
        end
    end

    // a finished move with nothing waiting drops the request
    a_move_end_idle: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        clk_en && move_end && !pend_q && !wr_move |=> !move_req_q)
        else $error("move request stayed up after completion");

    // reserved command bits never reach the queue engine
    a_move_dst_field: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        start_new |=> move_dst_q == $past(reg_wdata[29:16]))
        else $error("destination queue differs from bits 29-16");

    a_move_src_field: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        start_new |=> move_src_q == $past(reg_wdata[13:0]))
        else $error("source queue differs from bits 13-0");

    // pending slot holds one command while a move is running
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q      <= 1'b0;
            pend_head_q <= 1'b0;
            pend_dst_q  <= 14'h0000;
            pend_src_q  <= 14'h0000;
        end else if (clk_en) begin
            if (park_new) begin
                pend_q      <= 1'b1;
                pend_head_q <= cmd_head;
                pend_dst_q  <= cmd_dst;
                pend_src_q  <= cmd_src;
            end else if (take_pend) begin
                pend_q      <= 1'b0;
            end
        end
    end

    // a parked command waits and closes the command word
    a_move_park: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        park_new |=> pend_q && !reg_wr_ready_q
            && pend_src_q == $past(cmd_src))
        else $error("second command not parked");

    // writes to the command word are refused while the slot is full
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_wr_ready_q <= 1'b1;
        end else if (clk_en) begin
            reg_wr_ready_q <= !(park_new || (pend_q && !take_pend));
        end
    end

    // the command word is open exactly while the slot is empty
    a_ready_slot: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        reg_wr_ready_q == !pend_q)
        else $error("write ready disagrees with pending slot");

    // a refused write leaves the parked command untouched
    a_move_refused: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        wr_en && hit_move && !reg_wr_ready_q |=> $stable(pend_src_q)
            && $stable(pend_dst_q) && $stable(pend_head_q))
        else $error("refused command overwrote the pending slot");

    // linking address calculation
    qmc_link_if lk ();
    assign lk.idx       = link_idx;
    assign lk.idx_valid = link_idx_valid;
    assign lk.base0     = l0_base_q;
    assign lk.count0    = l0_count_q;
    assign lk.base1     = l1_base_q;
    assign link_addr       = lk.addr;
    assign link_addr_valid = lk.addr_valid;

    qmc_link_calc u_link (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .lk      (lk.calc)
    );

    // every mapping request is answered one cycle later
    a_link_answer: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        clk_en && link_idx_valid |=> link_addr_valid)
        else $error("mapping request got no answer");

    a_move_launch: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        wr_move && !move_req_q |=> move_req_q && move_src_q == $past(cmd_src)
            && move_dst_q == $past(cmd_dst))
        else $error("idle move write did not launch the move");
    a_move_head: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        wr_move && !move_req_q |=> move_head_q == $past(reg_wdata[31]))
        else $error("merge point differs from bit 31");
    a_move_atomic: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        move_req_q && !move_done |=> move_req_q && $stable(move_src_q)
            && $stable(move_dst_q) && $stable(move_head_q))
        else $error("running move changed before completion");
    a_move_pend_next: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        clk_en && move_end && pend_q |=> move_req_q
            && move_src_q == $past(pend_src_q))
        else $error("pending move not started after completion");
    a_move_read_zero: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        rd_en && hit_move |=> reg_rdata_q == 32'h0000_0000)
        else $error("command word did not read zero");
    a_rev_word_read: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        rd_en && hit_rev |=> reg_rdata_q[15:0] == {RV_RTL, RV_MAJ, RV_CUST,
            RV_MIN} && reg_rdata_q[31:30] == RV_SCHEME
            && reg_rdata_q[29:28] == 2'h0)
        else $error("revision word fields wrong");
    a_rev_func_read: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        rd_en && hit_rev |=> reg_rdata_q[27:16] == RV_FUNC
            && reg_rdata_q[7:6] == RV_CUST)
        else $error("revision function or custom field wrong");

    a_size_reserved: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        rd_en && hit_l0s |=> reg_rdata_q[31:19] == 13'h0000)
        else $error("size register upper bits not zero");
    a_size_store: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        wr_en && hit_l0s |=> l0_count_q == $past(reg_wdata[18:0]))
        else $error("size register did not take write");
    a_starve_group: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        rd_starve && grp_sel == 4'h0 |=>
            reg_rdata_q[7:0] == $past(starve_cnt[0]))
        else $error("starvation word 0 low byte wrong");
endmodule
`default_nettype wire

// [test/queue_manager_config_region_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module queue_manager_config_region_bench
    import qmc_pkg::*;
;
    // clock, reset and register port drive
    logic                  sys_clk;
    logic                  rst_n;
    logic                  clk_en;
    logic [ADDR_W-1:0]     reg_addr;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [DATA_W-1:0]     reg_wdata;
    logic [DATA_W-1:0]     reg_rdata_q;
    logic                  reg_wr_ready_q;
    logic                  move_req_q;
    logic                  move_head_q;
    logic [QNUM_W-1:0]     move_dst_q;
    logic [QNUM_W-1:0]     move_src_q;
    logic                  move_done;
    logic [LINK_IDX_W-1:0] link_idx;
    logic                  link_idx_valid;
    logic [31:0]           link_addr;
    logic                  link_addr_valid;
    logic [STARVE_NUM-1:0] starve_pop;
    int                    err_total;
    int                    num_checks;

    qmc_config_region dut_u (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .clk_en          (clk_en),
        .reg_addr        (reg_addr),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .reg_wdata       (reg_wdata),
        .reg_rdata_q     (reg_rdata_q),
        .reg_wr_ready_q  (reg_wr_ready_q),
        .move_req_q      (move_req_q),
        .move_head_q     (move_head_q),
        .move_dst_q      (move_dst_q),
        .move_src_q      (move_src_q),
        .move_done       (move_done),
        .link_idx        (link_idx),
        .link_idx_valid  (link_idx_valid),
        .link_addr       (link_addr),
        .link_addr_valid (link_addr_valid),
        .starve_pop      (starve_pop)
    );

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // compare one value and count it
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one word write, strobe held for a single cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // one word read; data lands on the edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(what, exp, reg_rdata_q);
    endtask

    // one mapping request, answer checked one cycle later
    task automatic link(input logic [18:0] idx, input logic [31:0] exp);
        @(posedge sys_clk);
        link_idx       <= idx;
        link_idx_valid <= 1'b1;
        @(posedge sys_clk);
        link_idx_valid <= 1'b0;
        #1;
        chk("link valid", 32'h1, {31'h0, link_addr_valid});
        chk("link addr", exp, link_addr);
    endtask

    // n separate empty-pop events on the masked queues
    task automatic pop(input logic [STARVE_NUM-1:0] m, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            starve_pop <= m;
            @(posedge sys_clk);
            starve_pop <= '0;
        end
    endtask

    // queue engine reports the current move finished
    task automatic done_pulse();
        @(posedge sys_clk);
        move_done <= 1'b1;
        @(posedge sys_clk);
        move_done <= 1'b0;
        #1;
    endtask

    // wait bounded for the next move to load, checking it stays requested
    task automatic wait_src(input logic [13:0] src);
        int i;
        for (i = 0; i < 20 && move_src_q !== src; i++) begin
            @(posedge sys_clk);
            #1;
            chk("move held", 32'h1, {31'h0, move_req_q});
        end
        chk("move src", {18'h0, src}, {18'h0, move_src_q});
    endtask

    task automatic end_test(input string name);
        $display("test %s done, checks %0d", name, num_checks);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // stop a hung run
    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    logic [31:0] rev_exp;
    assign rev_exp = {RV_SCHEME, 2'h0, RV_FUNC, RV_RTL, RV_MAJ, RV_CUST,
                      RV_MIN};

    // main sequence
    initial begin
        err_total = 0;
        num_checks = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0;
        move_done = 1'b0;
        link_idx = 19'h0;
        link_idx_valid = 1'b0;
        starve_pop = '0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;

        // identity and reset values
        rd(8'h00, rev_exp, "revision");
        wr(8'h00, 32'hffff_ffff);
        rd(8'h00, rev_exp, "revision ro");
        rd(8'h0c, 32'h0, "base0 reset");
        rd(8'h10, 32'h0, "size reset");
        rd(8'h08, 32'h0, "move read");
        rd(8'h04, 32'h0, "unmapped");
        end_test("reset");

        // linking map around the region 0 boundary
        wr(8'h0c, 32'h0000_1000);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, 32'h0007_ffff, "size width");
        wr(8'h10, 32'h0000_0005);
        wr(8'h14, 32'h0002_0000);
        rd(8'h0c, 32'h0000_1000, "base0");
        rd(8'h14, 32'h0002_0000, "base1");
        link(19'h0, 32'h0000_1000);
        link(19'h5, 32'h0000_1014);
        link(19'h6, 32'h0002_0000);
        link(19'h9, 32'h0002_000c);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(8'h0c, 32'h0000_2000);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(8'h0c, 32'h0000_1000, "frozen base0");
        end_test("link");

        // moves: head with junk reserved bits, then queued tail move
        wr(8'h08, 32'hc123_c005);
        chk("move req", 32'h1, {31'h0, move_req_q});
        chk("move head", 32'h1, {31'h0, move_head_q});
        chk("move dst", 32'h123, {18'h0, move_dst_q});
        chk("move src", 32'h5, {18'h0, move_src_q});
        wr(8'h08, 32'h0007_0009);
        @(posedge sys_clk);
        #1;
        chk("ready low", 32'h0, {31'h0, reg_wr_ready_q});
        chk("first kept", 32'h5, {18'h0, move_src_q});
        wr(8'h08, 32'h0003_0002);
        rd(8'h08, 32'h0, "move read busy");
        done_pulse();
        wait_src(14'h9);
        chk("tail", 32'h0, {31'h0, move_head_q});
        chk("dst 2", 32'h7, {18'h0, move_dst_q});
        repeat (2) @(posedge sys_clk);
        #1;
        chk("ready back", 32'h1, {31'h0, reg_wr_ready_q});
        done_pulse();
        repeat (3) @(posedge sys_clk);
        #1;
        chk("moves idle", 32'h0, {31'h0, move_req_q});
        end_test("move");

        // starvation counters: counts, saturation, clear on read
        pop(64'h3, 1);
        pop(64'h1, 2);
        pop(64'h80, 300);
        pop(64'h8000_0000_0000_0000, 1);
        rd(8'h20, 32'h0000_0103, "starve w0");
        rd(8'h20, 32'h0, "starve w0 clr");
        @(posedge sys_clk);
        starve_pop <= 64'h1;
        rd(8'h20, 32'h0000_0001, "starve race");
        @(posedge sys_clk);
        starve_pop <= '0;
        rd(8'h20, 32'h0000_0002, "starve set wins");
        rd(8'h20, 32'h0, "starve race clr");
        rd(8'h24, 32'hff00_0000, "starve sat");
        rd(8'h5c, 32'h0100_0000, "starve w15");
        rd(8'h21, 32'h0, "starve unaligned");
        end_test("starve");

        complete_run();
    end
endmodule
`default_nettype wire
